/* src/cmd_front_defines.vh */
// Constants for the command front end: opcodes, classes, status, sense codes
`ifndef CMD_FRONT_DEFINES_VH
`define CMD_FRONT_DEFINES_VH
// Operation codes
`define OP_TEST_READY 8'h00
`define OP_REZERO 8'h01
`define OP_REQ_SENSE 8'h03
`define OP_FORMAT 8'h04
`define OP_READ 8'h08
`define OP_WRITE 8'h0a
`define OP_SEEK 8'h0b
`define OP_TRANSLATE 8'h0f
`define OP_SET_THRESH 8'h10
`define OP_USAGE_CNT 8'h11
`define OP_INQUIRY 8'h12
`define OP_BUF_WRITE 8'h13
`define OP_BUF_READ 8'h14
`define OP_MODE_SELECT 8'h15
`define OP_RESERVE 8'h16
`define OP_RELEASE 8'h17
`define OP_MODE_SENSE 8'h1a
`define OP_START_STOP 8'h1b
`define OP_RECV_DIAG 8'h1c
`define OP_SEND_DIAG 8'h1d
`define OP_READ_CAP 8'h25
`define OP_READ_EXT 8'h28
`define OP_WRITE_EXT 8'h2a
`define OP_WRITE_VERIFY 8'h2e
`define OP_VERIFY 8'h2f
`define OP_SEARCH_EQ 8'h31
`define OP_SET_LIMITS 8'h33
// Source classes
`define CLASS_NONE 2'h0
`define CLASS_STD 2'h1
`define CLASS_VENDOR 2'h2
`define CLASS_SUBSET 2'h3
// Status byte values
`define STAT_GOOD 8'h00
`define STAT_CHECK 8'h02
`define STAT_BUSY 8'h08
`define STAT_RESERVED 8'h18
// Error codes and sense keys
`define ERR_NONE 8'h00
`define ERR_WRITE_FAULT 8'h03
`define ERR_NOT_READY 8'h04
`define ERR_SEL_FAIL 8'h05
`define ERR_BAD_ARG 8'h24
`define ERR_INVALID_OP 8'h20
`define KEY_NONE 4'h0
`define KEY_NOT_READY 4'h2
`define KEY_HW 4'h4
`define KEY_ILLEGAL 4'h5
// Register map
`define ADDR_STATUS 4'h0
`define ADDR_MASK 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_LAST_CMD 4'h3
`define ADDR_SENSE 4'h4
`define MASK_RESET 4'h0
`define CONTROL_RESET 8'h00
// Interrupt status bits
`define IRQ_CMD_DONE 0
`define IRQ_CHECK 1
`define IRQ_BAD_OP 2
`define IRQ_CHAN_DROP 3
`endif

/* src/sync_two_flop.v */
// Two-flop synchroniser for one asynchronous level
`default_nettype none
module sync_two_flop #(
   parameter RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // Level in and out
   input wire async_in,
   output reg sync_out
);
   reg meta_reg; // First stage, read only by the second

   ////////////////////////////////////////////////////////////////////////////
   // Two stages, constants under reset
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // sync_two_flop
`default_nettype wire

/* src/opcode_classifier.v */
// Opcode decoder giving the source class of a command byte
`default_nettype none
`include "cmd_front_defines.vh"
module opcode_classifier (
   // Command byte
   input wire [7:0] opcode,
   // Class, zero for an undecoded code
   output reg [1:0] op_class
);
   ////////////////////////////////////////////////////////////////////////////
   // Lookup of decoded codes
   always @* begin
      case (opcode)
         `OP_TEST_READY, `OP_REZERO, `OP_REQ_SENSE, `OP_READ, `OP_WRITE, `OP_SEEK,
         `OP_INQUIRY, `OP_RESERVE, `OP_RELEASE: op_class = `CLASS_STD;
         `OP_START_STOP, `OP_READ_CAP, `OP_READ_EXT, `OP_WRITE_EXT,
         `OP_SET_LIMITS: op_class = `CLASS_STD;
         `OP_TRANSLATE, `OP_SET_THRESH, `OP_USAGE_CNT, `OP_BUF_WRITE,
         `OP_BUF_READ: op_class = `CLASS_VENDOR;
         `OP_FORMAT, `OP_MODE_SELECT, `OP_MODE_SENSE, `OP_RECV_DIAG, `OP_SEND_DIAG,
         `OP_WRITE_VERIFY, `OP_VERIFY, `OP_SEARCH_EQ: op_class = `CLASS_SUBSET;
         default: op_class = `CLASS_NONE;
      endcase
   end
endmodule // opcode_classifier
`default_nettype wire

/* src/cmd_front.v */
// Command front end: opcode decode, test-unit-ready, remote channel control
// Registers: 0 status (write one to clear), 1 mask,
// 2 control (bit 0 forces channel down), 3 last opcode,
// 4 channel, pending flag and sense key
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`default_nettype none
`include "cmd_front_defines.vh"
module cmd_front (
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // Remote connector inputs, asynchronous
   input wire remote_chan_ready_in,
   input wire remote_reset_n_in,
   input wire remote_control_enable_jumper,
   // Command from the initiator side
   input wire cmd_valid,
   input wire [7:0] cmd_opcode,
   input wire [2:0] cmd_host_id,
   input wire [1:0] cmd_unit,
   // Drive state for the addressed unit
   input wire drive_powered,
   input wire drive_ready,
   input wire drive_busy,
   input wire drive_reserved,
   input wire drive_write_fault,
   input wire drive_selected_ok,
   input wire cmd_bad_arg,
   // Command answer
   output reg resp_valid,
   output reg [7:0] resp_status,
   output reg [1:0] resp_class,
   output reg exec_start,
   output reg [7:0] sense_code,
   output reg [3:0] sense_key,
   // Drive interface and internal reset
   output reg channel_ready,
   output reg ctrl_reset_n,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   wire chan_remote_sync; // Synchronised remote channel-ready
   wire reset_remote_sync; // Synchronised remote reset, low active
   wire jumper_sync; // Synchronised jumper level
   wire [1:0] op_class; // Class from the decoder
   wire core_rst_n; // Power-on or remote reset combined
   // Next values from the command evaluation
   reg [7:0] sense_code_next;
   reg [3:0] sense_key_next;
   reg [7:0] status_next;
   // Held sense and its owner
   reg sense_pending_reg; // Non-zero sense held
   reg [2:0] sense_owner_reg; // Host that got the check
   reg [1:0] sense_unit_reg; // Unit of the held sense
   // Interrupt and register file
   reg [3:0] irq_status_reg; // Sticky events
   reg [3:0] irq_mask_reg; // Event enables
   reg [7:0] control_reg; // Bit 0 forces channel down
   reg [7:0] last_cmd_reg; // Last opcode seen
   // Combinational helpers
   reg chan_next;
   reg set_pending;
   reg clr_pending;
   reg [3:0] events;
   reg [3:0] irq_status_next;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   // Two flops each; only the second stage is read
   // Remote channel-ready idles at drop under reset
   sync_two_flop #(.RESET_VAL(1'b1)) u_sync_chan (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(remote_chan_ready_in),
      .sync_out(chan_remote_sync)
   );
   // Remote reset holds the core until seen high
   sync_two_flop #(.RESET_VAL(1'b0)) u_sync_rst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(remote_reset_n_in),
      .sync_out(reset_remote_sync)
   );
   // Jumper level, read as removed under reset
   sync_two_flop #(.RESET_VAL(1'b0)) u_sync_jmp (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(remote_control_enable_jumper),
      .sync_out(jumper_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoder
   // Pure lookup, held by the answer register
   opcode_classifier u_classifier (
      .opcode(cmd_opcode),
      .op_class(op_class)
   );

   // Core stays in reset while the remote reset is grounded
   // Sync stage resets low, so power-on holds it too
   assign core_rst_n = reset_remote_sync;

   ////////////////////////////////////////////////////////////////////////////
   // Internal reset output
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         // Power-on reset drives the output low
         ctrl_reset_n <= 1'b0;
      end else begin
         // One flop after the core reset
         ctrl_reset_n <= core_rst_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel ready next value
   // Priority: reset, software, remote pin, default
   always @* begin
      if (!core_rst_n) begin
         chan_next = 1'b0; // Reset in progress
      end else if (control_reg[0]) begin
         chan_next = 1'b0; // Software override
      // Remote pin counts only with the jumper in
      end else if (jumper_sync) begin
         chan_next = ~chan_remote_sync;
      end else begin
         chan_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command evaluation
   // Priority: foreign host busy, request-sense,
   // unknown opcode, channel or selection, then
   // the test-unit-ready drive checks
   always @* begin
      // Defaults keep the held sense
      status_next = `STAT_GOOD;
      sense_code_next = sense_code;
      sense_key_next = sense_key;
      set_pending = 1'b0;
      clr_pending = 1'b0;
      if (sense_pending_reg && cmd_unit == sense_unit_reg && cmd_host_id != sense_owner_reg) begin
         status_next = `STAT_BUSY;
      end else if (cmd_opcode == `OP_REQ_SENSE) begin
         // Sense stays readable, released after this command
         status_next = `STAT_GOOD;
         clr_pending = 1'b1;
      end else begin
         // Owner's next command drops old sense
         sense_code_next = `ERR_NONE;
         sense_key_next = `KEY_NONE;
         clr_pending = 1'b1;
         // Error branches record sense and own it
         if (op_class == `CLASS_NONE) begin
            status_next = `STAT_CHECK;
            sense_code_next = `ERR_INVALID_OP;
            sense_key_next = `KEY_ILLEGAL;
            set_pending = 1'b1;
            // Channel down or no select answer next
         end else if (!channel_ready || !drive_selected_ok) begin
            status_next = `STAT_CHECK;
            sense_code_next = `ERR_SEL_FAIL;
            sense_key_next = `KEY_HW;
            set_pending = 1'b1;
         end else if (cmd_opcode == `OP_TEST_READY) begin
            // Argument, faults, readiness, then reservation
            if (cmd_bad_arg) begin
               status_next = `STAT_CHECK;
               sense_code_next = `ERR_BAD_ARG;
               sense_key_next = `KEY_ILLEGAL;
               set_pending = 1'b1;
            end else if (drive_write_fault) begin
               status_next = `STAT_CHECK;
               sense_code_next = `ERR_WRITE_FAULT;
               sense_key_next = `KEY_HW;
               set_pending = 1'b1;
            end else if (!drive_powered || !drive_ready) begin
               // Unit off or not spun up
               status_next = `STAT_CHECK;
               sense_code_next = `ERR_NOT_READY;
               sense_key_next = `KEY_NOT_READY;
               set_pending = 1'b1;
            end else if (drive_reserved) begin
               // Reserved wins over busy
               status_next = `STAT_RESERVED;
            end else if (drive_busy) begin
               status_next = `STAT_BUSY;
            end else begin
               status_next = `STAT_GOOD;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event collection and sticky status with set winning
   // A clear and an event in one cycle keep the bit
   always @* begin
      events = 4'h0;
      // Commands refused under remote reset raise nothing
      if (cmd_valid && core_rst_n) begin
         events[`IRQ_CMD_DONE] = 1'b1;
         events[`IRQ_CHECK] = (status_next == `STAT_CHECK);
         events[`IRQ_BAD_OP] = (op_class == `CLASS_NONE);
      end
      // Falling channel ready, whatever the cause
      events[`IRQ_CHAN_DROP] = channel_ready & ~chan_next;
      // Write one to clear, then merge new events
      irq_status_next = irq_status_reg;
      if (reg_wr && reg_addr == `ADDR_STATUS) begin
         irq_status_next = irq_status_reg & ~reg_wdata[3:0];
      end
      irq_status_next = irq_status_next | events;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command state and answer registers
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         resp_valid <= 1'b0;
         resp_status <= `STAT_GOOD;
         resp_class <= `CLASS_NONE;
         exec_start <= 1'b0;
         sense_code <= `ERR_NONE;
         sense_key <= `KEY_NONE;
         sense_pending_reg <= 1'b0;
         sense_owner_reg <= 3'h0;
         sense_unit_reg <= 2'h0;
         last_cmd_reg <= 8'h00;
         channel_ready <= 1'b0;
      end else begin
         // Channel follows its next value every cycle
         channel_ready <= chan_next;
         // Answer pulses default low
         resp_valid <= 1'b0;
         exec_start <= 1'b0;
         if (!core_rst_n) begin
            // Held in reset by the remote input
            sense_code <= `ERR_NONE;
            sense_key <= `KEY_NONE;
            sense_pending_reg <= 1'b0;
            resp_status <= `STAT_GOOD;
            resp_class <= `CLASS_NONE;
         end else if (cmd_valid) begin
            // Command taken: answer in the next cycle
            resp_valid <= 1'b1;
            resp_status <= status_next;
            resp_class <= op_class;
            // Kept for software, errors included
            last_cmd_reg <= cmd_opcode;
            sense_code <= sense_code_next;
            sense_key <= sense_key_next;
            // Good-status commands other than test-unit-ready and request-sense go on to execution
            exec_start <= (status_next == `STAT_GOOD) && (cmd_opcode != `OP_TEST_READY)
                          && (cmd_opcode != `OP_REQ_SENSE);
            // Remember owner and unit of a new check
            if (set_pending) begin
               sense_pending_reg <= 1'b1;
               sense_owner_reg <= cmd_host_id;
               sense_unit_reg <= cmd_unit;
            end else if (clr_pending) begin
               sense_pending_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and interrupt output
   // Mask and control take the write at the next edge
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status_reg <= 4'h0;
         // All events masked after reset
         irq_mask_reg <= `MASK_RESET;
         control_reg <= `CONTROL_RESET;
         irq <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         // Level interrupt from the fresh status
         irq <= |(irq_status_next & irq_mask_reg);
         if (reg_wr) begin
            // Status writes are handled with the events
            if (reg_addr == `ADDR_MASK) begin
               irq_mask_reg <= reg_wdata[3:0];
            end else if (reg_addr == `ADDR_CONTROL) begin
               control_reg <= reg_wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads, data in the following cycle
   // Read data stand one cycle, zero otherwise
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `ADDR_STATUS) begin
            reg_rdata <= {4'h0, irq_status_reg};
         end else if (reg_addr == `ADDR_MASK) begin
            reg_rdata <= {4'h0, irq_mask_reg};
         end else if (reg_addr == `ADDR_CONTROL) begin
            reg_rdata <= control_reg;
         end else if (reg_addr == `ADDR_LAST_CMD) begin
            reg_rdata <= last_cmd_reg;
         end else if (reg_addr == `ADDR_SENSE) begin
            // Channel, pending flag and sense key
            reg_rdata <= {channel_ready, sense_pending_reg, 2'h0, sense_key};
         end else begin
            reg_rdata <= 8'h00; // Unmapped
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // cmd_front
`default_nettype wire

/* testbench/cmd_front_asserts.sv */
// Port checks for the command front end
`default_nettype none
`include "cmd_front_defines.vh"
module cmd_front_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Remote pins and command
   input wire logic remote_chan_ready_in,
   input wire logic remote_reset_n_in,
   input wire logic remote_control_enable_jumper,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   // Answer and channel
   input wire logic resp_valid,
   input wire logic [7:0] resp_status,
   input wire logic [1:0] resp_class,
   input wire logic exec_start,
   input wire logic [7:0] sense_code,
   input wire logic [3:0] sense_key,
   input wire logic channel_ready,
   input wire logic ctrl_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_resp_next; cmd_valid && ctrl_reset_n |=> resp_valid; endproperty
   a_resp_next: assert property (p_resp_next) else $error("no answer after command");
   property p_resp_cause; resp_valid |-> $past(cmd_valid); endproperty
   a_resp_cause: assert property (p_resp_cause) else $error("answer without command");
   property p_bad_op; resp_valid && resp_class == `CLASS_NONE && resp_status != `STAT_BUSY
      |-> resp_status == `STAT_CHECK && sense_code == `ERR_INVALID_OP && sense_key == `KEY_ILLEGAL; endproperty
   a_bad_op: assert property (p_bad_op) else $error("unknown opcode answer wrong");
   property p_exec_good; exec_start |-> resp_valid && resp_status == `STAT_GOOD; endproperty
   a_exec_good: assert property (p_exec_good) else $error("start without good status");
   property p_chan_drop; (ctrl_reset_n && remote_control_enable_jumper && remote_chan_ready_in)[*4] |-> !channel_ready;
   endproperty
   a_chan_drop: assert property (p_chan_drop) else $error("channel not dropped");
   property p_chan_ignore; (ctrl_reset_n && !remote_control_enable_jumper)[*4] |-> channel_ready; endproperty
   a_chan_ignore: assert property (p_chan_ignore) else $error("remote pin not ignored");
   property p_reset_hold; (!remote_reset_n_in)[*4] |-> !ctrl_reset_n; endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("core not held in reset");
   property p_sel_fail; cmd_valid && ctrl_reset_n && !channel_ready && cmd_opcode == `OP_TEST_READY
      && sense_key == `KEY_NONE |=> resp_status == `STAT_CHECK && sense_code == `ERR_SEL_FAIL; endproperty
   a_sel_fail: assert property (p_sel_fail) else $error("channel down without selection error");
   property p_sense_kept; cmd_valid && ctrl_reset_n && cmd_opcode == `OP_REQ_SENSE |=> $stable(sense_code);
   endproperty
   a_sense_kept: assert property (p_sense_kept) else $error("sense lost on request");
endmodule // cmd_front_asserts
bind cmd_front cmd_front_asserts u_cmd_front_asserts (.ref_clk, .resetn, .remote_chan_ready_in, .remote_reset_n_in,
   .remote_control_enable_jumper, .cmd_valid, .cmd_opcode, .resp_valid, .resp_status, .resp_class, .exec_start,
   .sense_code, .sense_key, .channel_ready, .ctrl_reset_n);
`default_nettype wire

/* testbench/scsi_initiator_model.sv */
// Initiator model placing one-cycle commands on the request port
`default_nettype none
module scsi_initiator_model (
   // Clock and bench request
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [7:0] op,
   input wire logic [2:0] host,
   // Command port
   output var logic cmd_valid,
   output var logic [7:0] cmd_opcode,
   output var logic [2:0] cmd_host_id
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid = 1'b0;
      cmd_opcode = 8'h00;
      cmd_host_id = 3'h0;
   end
   // Idle fields flip each cycle so stale values never pass
   always @(posedge ref_clk) begin
      cmd_valid <= go;
      cmd_opcode <= go ? op : ~cmd_opcode;
      cmd_host_id <= go ? host : ~cmd_host_id;
   end
endmodule // scsi_initiator_model
`default_nettype wire

/* testbench/test_scsi_command_decode_unit_ready.sv */
// Self-checking bench for the command front end
`default_nettype none
`include "cmd_front_defines.vh"
module test_scsi_command_decode_unit_ready;
   timeunit 1ns;
   timeprecision 1ps;
   // Bench-driven inputs; drive bits: pwr,rdy,busy,rsv,wf,selok,badarg
   logic ref_clk = 1'b0, resetn = 1'b0, pin_chan = 1'b0, pin_rst_n = 1'b1, jumper = 1'b0, go = 1'b0;
   logic [7:0] op = 8'h00, reg_wdata = 8'h00;
   logic [2:0] host = 3'h0;
   logic [6:0] drv = 7'h23;
   logic [3:0] reg_addr = 4'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   // Model and design outputs
   wire cmd_valid, resp_valid, exec_start, channel_ready, ctrl_reset_n, irq;
   wire [7:0] cmd_opcode, resp_status, sense_code, reg_rdata;
   wire [2:0] cmd_host_id;
   wire [1:0] resp_class;
   wire [3:0] sense_key;
   int n_fail = 0, total_checks = 0, cycles = 0;
   // TUR table: drive state, status, {code,key}
   localparam logic [6:0] TD [7] = '{7'h23, 7'h27, 7'h2b, 7'h21, 7'h33, 7'h03, 7'h63};
   localparam logic [7:0] TS [7] = '{8'h00, 8'h08, 8'h18, 8'h02, 8'h02, 8'h02, 8'h02};
   localparam logic [11:0] TE [7] = '{12'h000, 12'h000, 12'h000, 12'h042, 12'h034, 12'h054, 12'h245};
   always #4 ref_clk = ~ref_clk;
   scsi_initiator_model u_scsi_initiator_model (.ref_clk(ref_clk), .go(go), .op(op), .host(host),
      .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_host_id(cmd_host_id));
   cmd_front u_cmd_front (.ref_clk(ref_clk), .resetn(resetn), .remote_chan_ready_in(pin_chan),
      .remote_reset_n_in(pin_rst_n), .remote_control_enable_jumper(jumper), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_host_id(cmd_host_id), .cmd_unit(2'h0), .drive_powered(drv[0]),
      .drive_ready(drv[1]), .drive_busy(drv[2]), .drive_reserved(drv[3]), .drive_write_fault(drv[4]),
      .drive_selected_ok(drv[5]), .cmd_bad_arg(drv[6]), .resp_valid(resp_valid), .resp_status(resp_status),
      .resp_class(resp_class), .exec_start(exec_start), .sense_code(sense_code), .sense_key(sense_key),
      .channel_ready(channel_ready), .ctrl_reset_n(ctrl_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Command issued through the model; returns in the answer cycle
   task automatic cmd(input logic [7:0] o, input logic [2:0] h);
      @(posedge ref_clk);
      go <= 1'b1;
      op <= o;
      host <= h;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic ans(input logic [7:0] st, input logic [11:0] e);
      chk1(resp_valid, 1'b1);
      chk(resp_status, st);
      chk(sense_code, e[11:4]);
      chk({4'h0, sense_key}, {4'h0, e[3:0]});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   function automatic logic [1:0] cls(input logic [7:0] o);
      case (o)
         8'h00, 8'h01, 8'h03, 8'h08, 8'h0a, 8'h0b, 8'h12,
         8'h16, 8'h17, 8'h1b, 8'h25, 8'h28, 8'h2a, 8'h33: cls = `CLASS_STD;
         8'h0f, 8'h10, 8'h11, 8'h13, 8'h14: cls = `CLASS_VENDOR;
         8'h04, 8'h15, 8'h1a, 8'h1c, 8'h1d, 8'h2e, 8'h2f, 8'h31: cls = `CLASS_SUBSET;
         default: cls = `CLASS_NONE;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // Every opcode, then sense ownership
   task automatic t_decode;
      logic [1:0] c;
      for (int i = 0; i < 256; i++) begin
         c = cls(i[7:0]);
         cmd(i[7:0], 3'h0);
         chk({6'h00, resp_class}, {6'h00, c});
         chk(resp_status, (c == `CLASS_NONE) ? `STAT_CHECK : `STAT_GOOD);
         chk1(exec_start, c != `CLASS_NONE && i != 0 && i != 3);
      end
      cmd(`OP_TEST_READY, 3'h1);
      ans(`STAT_BUSY, 12'h205);
      cmd(`OP_REQ_SENSE, 3'h0);
      ans(`STAT_GOOD, 12'h205);
      cmd(`OP_TEST_READY, 3'h0);
      ans(`STAT_GOOD, 12'h000);
      $display("decode test done");
   endtask
   // Drive states for test-unit-ready
   task automatic t_tur;
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         drv <= TD[i];
         cmd(`OP_TEST_READY, 3'h0);
         ans(TS[i], TE[i]);
         if (TS[i] == `STAT_CHECK) begin
            cmd(`OP_REQ_SENSE, 3'h0);
            ans(`STAT_GOOD, TE[i]);
         end
      end
      @(posedge ref_clk);
      drv <= 7'h23;
      cmd(`OP_TEST_READY, 3'h0);
      ans(`STAT_GOOD, 12'h000);
      $display("unit ready test done");
   endtask
   // Remote channel-ready pin with and without jumper
   task automatic t_remote;
      @(posedge ref_clk);
      pin_chan <= 1'b1;
      repeat (6) @(posedge ref_clk);
      jumper <= 1'b1;
      #1;
      chk1(channel_ready, 1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk1(channel_ready, 1'b1);
      @(posedge ref_clk);
      #1;
      chk1(channel_ready, 1'b0);
      cmd(`OP_TEST_READY, 3'h0);
      ans(`STAT_CHECK, 12'h054);
      @(posedge ref_clk);
      pin_chan <= 1'b0;
      repeat (4) @(posedge ref_clk);
      jumper <= 1'b0;
      #1;
      chk1(channel_ready, 1'b1);
      $display("remote test done");
   endtask
   // Status, mask, clear and unmapped read
   task automatic t_irq;
      rd(`ADDR_STATUS, 8'h0f);
      wr(`ADDR_MASK, 8'h00);
      wr(`ADDR_STATUS, 8'hff);
      cmd(8'hff, 3'h0);
      rd(`ADDR_STATUS, 8'h07);
      chk1(irq, 1'b0);
      wr(`ADDR_MASK, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1;
      chk1(irq, 1'b1);
      wr(`ADDR_STATUS, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1;
      chk1(irq, 1'b0);
      rd(`ADDR_STATUS, 8'h05);
      rd(`ADDR_LAST_CMD, 8'hff);
      rd(4'hf, 8'h00);
      $display("interrupt test done");
   endtask
   // Remote reset pin held low, then released
   task automatic t_reset;
      @(posedge ref_clk);
      pin_rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      chk1(ctrl_reset_n, 1'b0);
      cmd(`OP_TEST_READY, 3'h0);
      chk1(resp_valid, 1'b0);
      chk(sense_code, 8'h00);
      @(posedge ref_clk);
      pin_rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk1(ctrl_reset_n, 1'b1);
      $display("remote reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_decode();
      t_tur();
      t_remote();
      t_irq();
      t_reset();
      stop_test();
   end
endmodule // test_scsi_command_decode_unit_ready
`default_nettype wire
